/* File: rtl/asf_frame_if.sv */
`timescale 1ns/100ps
interface asf_frame_if;
    logic       start;
    logic [3:0] len;
    logic [3:0] rd_idx;
    logic [7:0] rd_byte;
    logic       busy;
    modport builder    (output start, len, rd_byte, input rd_idx, busy);
    modport serializer (input start, len, rd_byte, output rd_idx, busy);
endinterface : asf_frame_if

/* File: rtl/asf_framer.sv */
`timescale 1ns/100ps
//
// Contract
// - AT request answered by AT response frame
// - several responses per request are allowed
// - id at byte 4, command bytes 5-6
// - zero frame id suppresses the reply
// - AT status byte 7 codes 0 to 4
// - query appends data, write omits it
// - legacy transmit completion sends legacy status
// - legacy status 0x00 normal, 0x01 no ack
// - modem status codes at byte 4
// - hardware reset status sent after power-up
// - transmit completion sends transmit status frame
// - broadcast always reports delivery success
// - bytes 5-6 are 0xFFFE, retries byte 7
// - delivery status code at byte 8
// - discovery status 0x00 or 0x02 byte 9
module asf_framer import asf_pkg::*; (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // at command completion
    input  wire logic        at_req,
    input  wire logic        at_write,
    input  wire logic [7:0]  at_id,
    input  wire logic [15:0] at_cmd,
    input  wire logic [2:0]  at_status,
    input  wire logic [3:0]  at_len,
    input  wire logic [63:0] at_data,
    output logic             at_ack,
    // modem condition event
    input  wire logic        mdm_req,
    input  wire logic [7:0]  mdm_code,
    output logic             mdm_ack,
    // legacy transmit completion
    input  wire logic        ltx_req,
    input  wire logic [7:0]  ltx_id,
    input  wire logic        ltx_noack,
    output logic             ltx_ack,
    // transmit completion
    input  wire logic        tx_req,
    input  wire logic [7:0]  tx_id,
    input  wire logic [7:0]  tx_retry,
    input  wire logic [7:0]  tx_delivery,
    input  wire logic        tx_bcast,
    input  wire logic        tx_route_disc,
    output logic             tx_ack,
    // serial byte stream
    input  wire logic        out_ready,
    output logic             out_valid,
    output logic [7:0]       out_data
);
    asf_frame_if ifc();

    logic [7:0]       body [0:BODY_MAX-1];
    logic [LEN_W-1:0] len;
    logic             start;
    logic             pwr_pend;

    // ****************************************
    // arbitration
    // ****************************************
    wire ack_out  = at_ack | mdm_ack | ltx_ack | tx_ack;
    wire free     = !ifc.busy && !start && !ack_out;
    wire pwr_take = free && pwr_pend;
    wire mdm_take = free && !pwr_pend && mdm_req;
    wire at_take  = free && !pwr_pend && !mdm_req && at_req;
    wire tx_take  = free && !pwr_pend && !mdm_req && !at_req && tx_req;
    wire ltx_take = free && !pwr_pend && !mdm_req && !at_req && !tx_req && ltx_req;
    wire any_take = pwr_take | mdm_take | at_take | tx_take | ltx_take;

    // ****************************************
    // field encoding
    // ****************************************
    wire [3:0] at_clamp  = (at_len > AT_DATA_MAX) ? AT_DATA_MAX : at_len;
    wire [3:0] at_dlen   = at_write ? 4'h0 : at_clamp;
    wire [7:0] at_stat_b = {5'h00, at_status};
    wire [7:0] ltx_stat  = ltx_noack ? LTX_NO_ACK : LTX_NORMAL;
    wire [7:0] tx_deliv  = tx_bcast ? DLV_SUCCESS : tx_delivery;
    wire [7:0] tx_disc   = tx_route_disc ? DISC_ROUTE : DISC_NONE;

    wire [BODY_MAX*8-1:0] mdm_body = {88'h0, pwr_take ? MDM_HW_RESET : mdm_code, MDM_STAT_TYPE};
    wire [BODY_MAX*8-1:0] at_body  = {at_data, at_stat_b, at_cmd[7:0], at_cmd[15:8],
                                      at_id, AT_RSP_TYPE};
    wire [BODY_MAX*8-1:0] tx_body  = {48'h0, tx_disc, tx_deliv, tx_retry,
                                      TX_RESERVED[7:0], TX_RESERVED[15:8], tx_id, TX_STAT_TYPE};
    wire [BODY_MAX*8-1:0] ltx_body = {80'h0, ltx_stat, ltx_id, LTX_STAT_TYPE};

    wire [BODY_MAX*8-1:0] next_body = (pwr_take || mdm_take) ? mdm_body :
                                      at_take ? at_body : tx_take ? tx_body : ltx_body;
    wire [LEN_W-1:0] next_len = (pwr_take || mdm_take) ? MDM_LEN :
                                at_take ? LEN_W'(AT_BASE_LEN + at_dlen) :
                                tx_take ? TX_LEN : LTX_LEN;
    wire id_zero = (at_take && at_id == NO_REPLY_ID) ||
                   (tx_take && tx_id == NO_REPLY_ID) ||
                   (ltx_take && ltx_id == NO_REPLY_ID);
    wire next_start = any_take && !id_zero;

    // ****************************************
    // frame buffer
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            start    <= 1'b0;
            pwr_pend <= 1'b1;
            len      <= '0;
            at_ack   <= 1'b0;
            mdm_ack  <= 1'b0;
            ltx_ack  <= 1'b0;
            tx_ack   <= 1'b0;
        end else begin
            start    <= next_start;
            pwr_pend <= pwr_pend && !pwr_take;
            at_ack   <= at_take;
            mdm_ack  <= mdm_take;
            ltx_ack  <= ltx_take;
            tx_ack   <= tx_take;
            if (next_start) begin
                len <= next_len;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < BODY_MAX; i++) begin
                body[i] <= '0;
            end
        end else if (next_start) begin
            for (int i = 0; i < BODY_MAX; i++) begin
                body[i] <= next_body[i*8 +: 8];
            end
        end
    end

    assign ifc.start   = start;
    assign ifc.len     = len;
    assign ifc.rd_byte = (ifc.rd_idx < BODY_MAX) ? body[ifc.rd_idx] : 8'h00;

    asf_serializer u_ser (
        .clock     (clock),
        .rstn      (rstn),
        .ifc       (ifc),
        .out_ready (out_ready),
        .out_valid (out_valid),
        .out_data  (out_data)
    );

    // ****************************************
    // checks
    // ****************************************
    a_at_reply: assert property (@(posedge clock) disable iff (!rstn)
        (at_take && at_id != NO_REPLY_ID) |=> start && body[B_TYPE] == AT_RSP_TYPE
            && body[B_ID] == $past(at_id))
        else $error("AT reply not built");
    a_zero_id: assert property (@(posedge clock) disable iff (!rstn)
        (any_take && id_zero) |=> !start ##1 !start)
        else $error("zero id frame was sent");
    a_at_write: assert property (@(posedge clock) disable iff (!rstn)
        (at_take && at_write && at_id != NO_REPLY_ID) |=> len == AT_BASE_LEN)
        else $error("write reply carries data");
    a_ltx_stat: assert property (@(posedge clock) disable iff (!rstn)
        (ltx_take && ltx_id != NO_REPLY_ID) |=> body[B_LTX_STAT] ==
            ($past(ltx_noack) ? LTX_NO_ACK : LTX_NORMAL) && len == LTX_LEN)
        else $error("legacy status wrong");
    a_power_up: assert property (@(posedge clock) disable iff (!rstn)
        pwr_take |=> start && !pwr_pend && body[B_TYPE] == MDM_STAT_TYPE
            && body[B_MDM_STAT] == MDM_HW_RESET)
        else $error("power-up status missing");
    a_bcast_ok: assert property (@(posedge clock) disable iff (!rstn)
        (tx_take && tx_bcast && tx_id != NO_REPLY_ID) |=> body[B_TX_DELIV] == DLV_SUCCESS)
        else $error("broadcast not reported as success");
    a_tx_rsv: assert property (@(posedge clock) disable iff (!rstn)
        (tx_take && tx_id != NO_REPLY_ID) |=> body[B_TX_RSV_HI] == TX_RESERVED[15:8]
            && body[B_TX_RSV_LO] == TX_RESERVED[7:0] && len == TX_LEN)
        else $error("transmit status reserved field wrong");
    a_tx_disc: assert property (@(posedge clock) disable iff (!rstn)
        (tx_take && tx_id != NO_REPLY_ID) |=> body[B_TX_DISC] ==
            ($past(tx_route_disc) ? DISC_ROUTE : DISC_NONE))
        else $error("discovery status wrong");
    a_one_ack: assert property (@(posedge clock) disable iff (!rstn)
        ack_out |-> !free ##1 !ack_out)
        else $error("ack longer than one cycle");
    a_at_cmd: assert property (@(posedge clock) disable iff (!rstn)
        (at_take && at_id != NO_REPLY_ID) |=> body[B_AT_CMD_HI] == $past(at_cmd[15:8])
            && body[B_AT_CMD_LO] == $past(at_cmd[7:0]))
        else $error("AT command bytes wrong");
    a_at_status: assert property (@(posedge clock) disable iff (!rstn)
        (at_take && at_id != NO_REPLY_ID) |=> body[B_AT_STAT] == {5'h00, $past(at_status)})
        else $error("AT status byte wrong");
    a_at_query: assert property (@(posedge clock) disable iff (!rstn)
        (at_take && !at_write && at_id != NO_REPLY_ID && at_len <= AT_DATA_MAX) |=>
            len == LEN_W'(AT_BASE_LEN + $past(at_len)) && body[B_AT_DATA] == $past(at_data[7:0]))
        else $error("query reply data wrong");
    a_ltx_reply: assert property (@(posedge clock) disable iff (!rstn)
        (ltx_take && ltx_id != NO_REPLY_ID) |=> start && body[B_TYPE] == LTX_STAT_TYPE
            && body[B_ID] == $past(ltx_id))
        else $error("legacy status not built");
    a_mdm_code: assert property (@(posedge clock) disable iff (!rstn)
        mdm_take |=> start && body[B_TYPE] == MDM_STAT_TYPE
            && body[B_MDM_STAT] == $past(mdm_code) && len == MDM_LEN)
        else $error("modem status wrong");
    a_tx_reply: assert property (@(posedge clock) disable iff (!rstn)
        (tx_take && tx_id != NO_REPLY_ID) |=> start && body[B_TYPE] == TX_STAT_TYPE
            && body[B_ID] == $past(tx_id))
        else $error("transmit status not built");
    a_tx_deliv: assert property (@(posedge clock) disable iff (!rstn)
        (tx_take && !tx_bcast && tx_id != NO_REPLY_ID) |=> body[B_TX_DELIV] ==
            $past(tx_delivery) && body[B_TX_RETRY] == $past(tx_retry))
        else $error("delivery or retry byte wrong");
    a_one_source: assert property (@(posedge clock) disable iff (!rstn)
        $onehot0({pwr_take, mdm_take, at_take, tx_take, ltx_take}))
        else $error("two sources taken at once");
    a_start_idle: assert property (@(posedge clock) disable iff (!rstn)
        start |-> !ifc.busy)
        else $error("frame launched while busy");
    a_pwr_once: assert property (@(posedge clock) disable iff (!rstn)
        !pwr_pend |=> !pwr_pend)
        else $error("power-up status repeated");
endmodule : asf_framer

/* File: rtl/asf_pkg.sv */
package asf_pkg;
    // ****************************************
    // frame layout
    // ****************************************
    localparam logic [7:0] FRAME_DELIM   = 8'h7E;
    localparam logic [7:0] LEN_HI_BYTE   = 8'h00;
    localparam logic [7:0] AT_RSP_TYPE   = 8'h88;
    localparam logic [7:0] LTX_STAT_TYPE = 8'h89;
    localparam logic [7:0] MDM_STAT_TYPE = 8'h8A;
    localparam logic [7:0] TX_STAT_TYPE  = 8'h8B;
    localparam logic [7:0] NO_REPLY_ID   = 8'h00;
    localparam int         BODY_MAX      = 13;
    localparam int         LEN_W         = 4;
    localparam logic [3:0] AT_BASE_LEN   = 4'h5;
    localparam logic [3:0] AT_DATA_MAX   = 4'h8;
    localparam logic [3:0] MDM_LEN       = 4'h2;
    localparam logic [3:0] LTX_LEN       = 4'h3;
    localparam logic [3:0] TX_LEN        = 4'h7;
    // body index = frame offset minus 3
    localparam int         B_TYPE        = 0;
    localparam int         B_ID          = 1;
    localparam int         B_LTX_STAT    = 2;
    localparam int         B_MDM_STAT    = 1;
    localparam int         B_TX_RSV_HI   = 2;
    localparam int         B_TX_RSV_LO   = 3;
    localparam int         B_TX_DELIV    = 5;
    localparam int         B_TX_DISC     = 6;
    localparam int         B_AT_CMD_HI   = 2;
    localparam int         B_AT_CMD_LO   = 3;
    localparam int         B_AT_STAT     = 4;
    localparam int         B_AT_DATA     = 5;
    localparam int         B_TX_RETRY    = 4;
    // ****************************************
    // status encodings
    // ****************************************
    localparam logic [2:0] AT_OK         = 3'h0;
    localparam logic [2:0] AT_ERROR      = 3'h1;
    localparam logic [2:0] AT_BAD_CMD    = 3'h2;
    localparam logic [2:0] AT_BAD_PARAM  = 3'h3;
    localparam logic [2:0] AT_TX_FAIL    = 3'h4;
    localparam logic [7:0] LTX_NORMAL    = 8'h00;
    localparam logic [7:0] LTX_NO_ACK    = 8'h01;
    localparam logic [7:0] MDM_HW_RESET  = 8'h00;
    localparam logic [7:0] MDM_WDOG      = 8'h01;
    localparam logic [7:0] MDM_WAKE      = 8'h0B;
    localparam logic [7:0] MDM_SLEEP     = 8'h0C;
    localparam logic [15:0] TX_RESERVED  = 16'hFFFE;
    localparam logic [7:0] DLV_SUCCESS   = 8'h00;
    localparam logic [7:0] DLV_MAC_ACK   = 8'h01;
    localparam logic [7:0] DLV_CCA       = 8'h02;
    localparam logic [7:0] DLV_NET_ACK   = 8'h21;
    localparam logic [7:0] DLV_NO_ROUTE  = 8'h25;
    localparam logic [7:0] DLV_RESOURCE  = 8'h31;
    localparam logic [7:0] DLV_INTERNAL  = 8'h32;
    localparam logic [7:0] DLV_TOO_LARGE = 8'h74;
    localparam logic [7:0] DLV_INDIRECT  = 8'h75;
    localparam logic [7:0] DISC_NONE     = 8'h00;
    localparam logic [7:0] DISC_ROUTE    = 8'h02;

    function automatic logic [7:0] asf_checksum(input logic [7:0] sum);
        return 8'hFF - sum;
    endfunction : asf_checksum
endpackage : asf_pkg

/* File: rtl/asf_serializer.sv */
`timescale 1ns/100ps
module asf_serializer import asf_pkg::*; (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // frame buffer side
    asf_frame_if.serializer  ifc,
    // byte stream
    input  wire logic        out_ready,
    output logic             out_valid,
    output logic [7:0]       out_data
);
    typedef enum logic [2:0] {
        SER_IDLE, SER_DELIM, SER_LEN_HI, SER_LEN_LO, SER_BODY, SER_SUM
    } asf_ser_state_type;

    asf_ser_state_type state;
    asf_ser_state_type next_state;
    logic [3:0]        idx;
    logic [7:0]        sum;
    logic [3:0]        next_idx;
    logic [7:0]        next_sum;
    logic [7:0]        next_data;
    logic              next_valid;

    wire accept = out_valid && out_ready;
    wire last   = (idx == ifc.len);

    assign ifc.rd_idx = idx;
    assign ifc.busy   = (state != SER_IDLE);

    // ****************************************
    // byte sequencing
    // ****************************************
    always_comb begin
        next_state = state;
        next_idx   = idx;
        next_sum   = sum;
        next_data  = out_data;
        next_valid = out_valid;
        unique case (state)
            SER_IDLE: begin
                if (ifc.start) begin
                    next_state = SER_DELIM;
                    next_data  = FRAME_DELIM;
                    next_valid = 1'b1;
                end
            end
            SER_DELIM: begin
                if (accept) begin
                    next_state = SER_LEN_HI;
                    next_data  = LEN_HI_BYTE;
                end
            end
            SER_LEN_HI: begin
                if (accept) begin
                    next_state = SER_LEN_LO;
                    next_data  = {4'h0, ifc.len};
                    next_idx   = '0;
                end
            end
            SER_LEN_LO, SER_BODY: begin
                if (accept) begin
                    if (state == SER_BODY && last) begin
                        next_state = SER_SUM;
                        next_data  = asf_checksum(sum);
                    end else begin
                        next_state = SER_BODY;
                        next_data  = ifc.rd_byte;
                        next_sum   = (state == SER_LEN_LO) ? ifc.rd_byte : sum + ifc.rd_byte;
                        next_idx   = idx + 4'h1;
                    end
                end
            end
            SER_SUM: begin
                if (accept) begin
                    next_state = SER_IDLE;
                    next_valid = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state     <= SER_IDLE;
            idx       <= '0;
            sum       <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            state     <= next_state;
            idx       <= next_idx;
            sum       <= next_sum;
            out_valid <= next_valid;
            out_data  <= next_data;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_delim_first: assert property (@(posedge clock) disable iff (!rstn)
        (state == SER_IDLE && ifc.start) |=> out_valid && out_data == FRAME_DELIM)
        else $error("frame did not open with delimiter");
    a_sum_closes: assert property (@(posedge clock) disable iff (!rstn)
        (state == SER_SUM && accept) |=> !out_valid && state == SER_IDLE)
        else $error("frame did not end after checksum");
    a_byte_held: assert property (@(posedge clock) disable iff (!rstn)
        (out_valid && !out_ready) |=> out_valid && $stable(out_data))
        else $error("byte changed while stalled");
endmodule : asf_serializer

/* File: test/asf_framer_tb.sv */
`timescale 1ns/100ps
module asf_framer_tb;
    // ****************************************
    // signals
    // ****************************************
    logic clock, rstn, slow, at_req, at_write, at_ack, mdm_req, mdm_ack;
    logic ltx_req, ltx_noack, ltx_ack, tx_req, tx_bcast, tx_route_disc, tx_ack;
    logic out_ready, out_valid;
    logic [7:0] at_id, mdm_code, ltx_id, tx_id, tx_retry, tx_delivery, out_data;
    logic [15:0] at_cmd;
    logic [2:0] at_status;
    logic [3:0] at_len;
    logic [63:0] at_data;
    int err_count = 0;
    int n_tests = 0;

    asf_framer i_dut (.clock(clock), .rstn(rstn), .at_req(at_req), .at_write(at_write),
        .at_id(at_id), .at_cmd(at_cmd), .at_status(at_status), .at_len(at_len),
        .at_data(at_data), .at_ack(at_ack), .mdm_req(mdm_req), .mdm_code(mdm_code),
        .mdm_ack(mdm_ack), .ltx_req(ltx_req), .ltx_id(ltx_id), .ltx_noack(ltx_noack),
        .ltx_ack(ltx_ack), .tx_req(tx_req), .tx_id(tx_id), .tx_retry(tx_retry),
        .tx_delivery(tx_delivery), .tx_bcast(tx_bcast), .tx_route_disc(tx_route_disc),
        .tx_ack(tx_ack), .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data));
    asf_host_model i_host (.clock(clock), .rstn(rstn), .slow(slow),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

    always #12.5 clock = ~clock;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // kind 0 modem, 1 at, 2 legacy, 3 transmit
    task automatic fire(input int kind);
        int k;
        {mdm_req, at_req, ltx_req, tx_req} = 4'h8 >> kind;
        for (k = 0; k < 400; k++) begin
            @(posedge clock);
            #1;
            if ({mdm_ack, at_ack, ltx_ack, tx_ack} !== 4'h0) break;
        end
        check({mdm_ack, at_ack, ltx_ack, tx_ack}, 64'h8 >> kind);
        {mdm_req, at_req, ltx_req, tx_req} = 4'h0;
        @(posedge clock);
        #1;
    endtask : fire

    task automatic expect_frame(input logic [7:0] body[$]);
        logic [7:0] f[$];
        logic [7:0] sum;
        int k;
        sum = 8'h00;
        foreach (body[i]) sum += body[i];
        f = {8'h7E, 8'h00, 8'(body.size()), body, 8'hFF - sum};
        for (k = 0; k < 400 && i_host.rx_q.size() < f.size(); k++) begin
            @(posedge clock);
            #1;
        end
        check(i_host.rx_q.size() >= f.size(), 1);
        foreach (f[i]) begin
            if (i_host.rx_q.size() > 0) check(i_host.rx_q.pop_front(), f[i]);
        end
    endtask : expect_frame

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rstn = 1'b0;
        repeat (2) @(posedge clock);
        #1 rstn = 1'b1;
        @(posedge clock);
        #1;
        check({out_valid, mdm_ack, at_ack, ltx_ack, tx_ack}, 64'h0);
        expect_frame('{8'h8A, 8'h00});
    endtask : t_reset

    task automatic t_modem;
        logic [7:0] codes[4] = '{8'h01, 8'h0B, 8'h0C, 8'h00};
        foreach (codes[i]) begin
            mdm_code = codes[i];
            fire(0);
            expect_frame('{8'h8A, codes[i]});
        end
    endtask : t_modem

    task automatic t_at;
        logic [7:0] b[$];
        int s, k;
        at_cmd = 16'h4E44;
        at_data = 64'h8877665544332211;
        for (s = 0; s < 5; s++) begin
            at_id = 8'h10 + 8'(s);
            at_status = 3'(s);
            at_len = 4'(2 * s);
            fire(1);
            b = '{8'h88, at_id, 8'h4E, 8'h44, 8'(s)};
            for (k = 0; k < 2 * s; k++) b.push_back(at_data[8*k +: 8]);
            expect_frame(b);
        end
        // back-to-back replies, oversize length clamps
        at_len = 4'hF;
        fire(1);
        fire(1);
        b = '{8'h88, 8'h14, 8'h4E, 8'h44, 8'h04};
        for (k = 0; k < 8; k++) b.push_back(at_data[8*k +: 8]);
        expect_frame(b);
        expect_frame(b);
        at_write = 1'b1;
        at_id = 8'h01;
        at_cmd = 16'h4244;
        at_status = 3'h0;
        at_len = 4'h3;
        fire(1);
        expect_frame('{8'h88, 8'h01, 8'h42, 8'h44, 8'h00});
        at_write = 1'b0;
    endtask : t_at

    task automatic t_legacy;
        int n;
        slow = 1'b1;
        for (n = 0; n < 2; n++) begin
            ltx_id = 8'h21 + 8'(n);
            ltx_noack = n[0];
            fire(2);
            expect_frame('{8'h89, ltx_id, 8'(n)});
        end
        slow = 1'b0;
    endtask : t_legacy

    task automatic t_tx;
        logic [7:0] codes[10] = '{8'h00, 8'h01, 8'h02, 8'h21, 8'h25, 8'h31, 8'h32, 8'h74,
                                  8'h75, 8'h21};
        foreach (codes[i]) begin
            tx_id = 8'h40 + 8'(i);
            tx_retry = 8'(i);
            tx_delivery = codes[i];
            tx_bcast = (i == 9);
            tx_route_disc = i[0];
            fire(3);
            expect_frame('{8'h8B, tx_id, 8'hFF, 8'hFE, 8'(i), (i == 9) ? 8'h00 : codes[i],
                           i[0] ? 8'h02 : 8'h00});
        end
    endtask : t_tx

    task automatic t_suppress;
        at_id = 8'h00;
        ltx_id = 8'h00;
        tx_id = 8'h00;
        fire(1);
        fire(2);
        fire(3);
        repeat (40) @(posedge clock);
        #1;
        check(i_host.rx_q.size(), 0);
    endtask : t_suppress

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        clock = 1'b0;
        slow = 1'b0;
        {at_req, at_write, mdm_req, ltx_req, ltx_noack, tx_req, tx_bcast} = 7'h00;
        {at_id, mdm_code, ltx_id, tx_id, tx_retry, tx_delivery, tx_route_disc} = 49'h0;
        {at_cmd, at_status, at_len, at_data} = 87'h0;
        t_reset;
        t_modem;
        t_at;
        t_legacy;
        t_tx;
        t_suppress;
        t_reset;
        summarize;
    end

    initial begin
        #500000;
        err_count++;
        summarize;
    end
endmodule : asf_framer_tb

/* File: test/asf_host_model.sv */
`timescale 1ns/100ps
module asf_host_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // pacing select
    input  wire logic       slow,
    // byte stream
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    output logic            out_ready
);
    // ****************************************
    // receive queue
    // ****************************************
    logic [7:0] rx_q[$];
    logic [1:0] phase;

    initial begin
        out_ready = 1'b0;
        phase = 2'h0;
    end

    // ready once in four cycles when slow
    always @(posedge clock) begin
        #1;
        phase = phase + 2'h1;
        out_ready = rstn && (!slow || phase == 2'h2);
    end

    // mid-cycle sample equals the accepting edge
    always @(negedge clock) begin
        if (rstn && out_valid === 1'b1 && out_ready) begin
            rx_q.push_back(out_data);
        end
    end
endmodule : asf_host_model
